// ### hdl/atig_pkg.sv
// Package with register map, field layout and carrier types for the event generators
package atig_pkg;
  localparam logic [7:0] ATIG_EVENT1_CONFIG_ADDR = 8'h30;
  localparam logic [7:0] ATIG_EVENT1_SOURCE_ADDR = 8'h31;
  localparam logic [7:0] ATIG_EVENT1_THRESHOLD_ADDR = 8'h32;
  localparam logic [7:0] ATIG_EVENT1_MIN_DURATION_ADDR = 8'h33;
  localparam logic [7:0] ATIG_EVENT2_CONFIG_ADDR = 8'h34;
  localparam logic [7:0] ATIG_EVENT2_SOURCE_ADDR = 8'h35;
  localparam logic [7:0] ATIG_EVENT2_THRESHOLD_ADDR = 8'h36;
  localparam logic [7:0] ATIG_EVENT2_MIN_DURATION_ADDR = 8'h37;
  localparam int ATIG_SRC_ACTIVE_BIT = 6;
  localparam int ATIG_CFG_AOI_BIT = 7;
  localparam int ATIG_CFG_6D_BIT = 6;
  localparam logic [7:0] ATIG_CFG_RESET = 8'h00;
  localparam logic [6:0] ATIG_FIELD7_RESET = 7'h00;
  localparam logic [5:0] ATIG_FLAGS_RESET = 6'h00;
  localparam logic [7:0] ATIG_READ_ZERO = 8'h00;
  localparam logic [7:0] ATIG_DUR_ONE = 8'h01;

  typedef enum logic [1:0] {
    ATIG_MODE_OR,
    ATIG_MODE_MOVE6D,
    ATIG_MODE_AND,
    ATIG_MODE_POS6D
  } atig_mode_e;

  // Per-generator settings
  typedef struct packed {
    logic and_or_select;
    logic six_direction_enable;
    logic [5:0] axis_enable;
    logic [6:0] threshold_level;
    logic [6:0] duration_count;
  } atig_gen_cfg_s;

  // Three signed axis magnitudes, high part of each sample
  typedef struct packed {
    logic signed [7:0] z;
    logic signed [7:0] y;
    logic signed [7:0] x;
  } atig_sample_s;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } atig_req_s;
endpackage

// ### hdl/atig_event_gen.sv
// One threshold event generator: compare, combine, duration filter, source register
`timescale 1ns/1ps
module atig_event_gen
  import atig_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_tick,
  input wire logic latch_enable,
  input wire atig_sample_s sample,
  input atig_gen_cfg_s cfg,
  input wire logic source_read,
  output logic [7:0] source_value,
  output logic int_pin
);
  typedef struct packed {
    logic [5:0] flags;
    logic active;
    logic [6:0] dur_cnt;
    logic [5:0] prev_pos;
    logic frozen;
  } atig_gen_state_s;

  atig_gen_state_s st_reg;
  atig_gen_state_s st_next;
  logic [5:0] raw_ev;
  logic [5:0] en_ev;
  logic cond;
  logic [5:0] cur_pos;
  atig_mode_e mode;
  logic signed [7:0] ax [3];
  logic signed [7:0] ths_pos;
  logic signed [7:0] ths_neg;

  assign ax[0] = sample.x;
  assign ax[1] = sample.y;
  assign ax[2] = sample.z;
  assign ths_pos = $signed({1'b0, cfg.threshold_level});
  assign ths_neg = -ths_pos;
  assign mode = atig_mode_e'({cfg.and_or_select, cfg.six_direction_enable}); // [R13] [R14] [R15]

  // Bit 2k is low, 2k+1 is high, matching the source flag order
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      assign raw_ev[2*g+1] = ax[g] > ths_pos; // [R11]
      assign raw_ev[2*g] = ax[g] < ths_neg; // [R12]
      assign cur_pos[2*g+1] = raw_ev[2*g+1];
      assign cur_pos[2*g] = raw_ev[2*g];
    end
  endgenerate

  assign en_ev = raw_ev & cfg.axis_enable; // [R11] [R12]

  always_comb begin
    case (mode)
      ATIG_MODE_OR: cond = |en_ev; // [R13] [R16]
      ATIG_MODE_AND: cond = (cfg.axis_enable != 6'h00) &&
                            ((en_ev == cfg.axis_enable)); // [R16]
      // Movement: a newly entered enabled direction
      ATIG_MODE_MOVE6D: cond = |(en_ev & ~st_reg.prev_pos); // [R14]
      // Position: held in exactly one enabled direction
      ATIG_MODE_POS6D: cond = (en_ev != 6'h00) && ((en_ev & (en_ev - 6'h01)) == 6'h00); // [R14]
      default: cond = 1'b0;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    if (sample_tick) begin
      st_next.prev_pos = cur_pos & cfg.axis_enable;
      // Duration counts in samples, so its step follows the sample rate
      if (!cond) begin
        st_next.dur_cnt = ATIG_FIELD7_RESET;
      end else if (st_reg.dur_cnt != cfg.duration_count) begin
        st_next.dur_cnt = st_reg.dur_cnt + 7'h01; // [R8] [R9]
      end
    end
    if (latch_enable) begin
      if (source_read) begin
        st_next.frozen = 1'b0; // [R4] [R6] [R5]
        st_next.active = 1'b0;
        st_next.flags = ATIG_FLAGS_RESET;
      end
      // Event on the read cycle still lands; set wins over clear
      if (sample_tick && cond && st_reg.dur_cnt == cfg.duration_count &&
          (!st_reg.frozen || source_read)) begin
        st_next.active = 1'b1; // [R2] [R5]
        st_next.flags = en_ev; // [R3]
        st_next.frozen = 1'b1;
      end
    end else begin
      st_next.frozen = 1'b0;
      if (sample_tick) begin
        st_next.active = cond && st_reg.dur_cnt == cfg.duration_count; // [R17] [R2]
        st_next.flags = cond ? en_ev : ATIG_FLAGS_RESET; // [R17] [R3]
      end
      if (source_read && !sample_tick) begin
        st_next.active = 1'b0; // [R4] [R6]
      end
    end
    if (rst) begin
      st_next = '0; // [R1]
    end
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign source_value = {1'b0, st_reg.active, st_reg.flags}; // [R1] [R18]
  assign int_pin = st_reg.active; // [R4] [R6]
endmodule

// ### hdl/atig_regs.sv
// Register file for both generators: config, threshold, duration
`timescale 1ns/1ps
module atig_regs
  import atig_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input atig_req_s req,
  output atig_gen_cfg_s cfg1,
  output atig_gen_cfg_s cfg2
);
  typedef struct packed {
    atig_gen_cfg_s c1;
    atig_gen_cfg_s c2;
  } atig_regs_state_s;

  atig_regs_state_s st_reg;
  atig_regs_state_s st_next;

  always_comb begin
    st_next = st_reg;
    if (req.wr) begin
      case (req.addr)
        ATIG_EVENT1_CONFIG_ADDR: begin
          st_next.c1.and_or_select = req.wdata[ATIG_CFG_AOI_BIT]; // [R10] [R15]
          st_next.c1.six_direction_enable = req.wdata[ATIG_CFG_6D_BIT];
          st_next.c1.axis_enable = req.wdata[5:0];
        end
        ATIG_EVENT1_THRESHOLD_ADDR: st_next.c1.threshold_level = req.wdata[6:0]; // [R7] [R18]
        ATIG_EVENT1_MIN_DURATION_ADDR: st_next.c1.duration_count = req.wdata[6:0]; // [R8]
        ATIG_EVENT2_CONFIG_ADDR: begin
          st_next.c2.and_or_select = req.wdata[ATIG_CFG_AOI_BIT]; // [R10]
          st_next.c2.six_direction_enable = req.wdata[ATIG_CFG_6D_BIT];
          st_next.c2.axis_enable = req.wdata[5:0];
        end
        ATIG_EVENT2_THRESHOLD_ADDR: st_next.c2.threshold_level = req.wdata[6:0]; // [R7]
        ATIG_EVENT2_MIN_DURATION_ADDR: st_next.c2.duration_count = req.wdata[6:0]; // [R8]
        default: st_next = st_reg;
      endcase
    end
    if (rst) begin
      st_next = '0; // [R7] [R8] [R10]
    end
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign cfg1 = st_reg.c1;
  assign cfg2 = st_reg.c2;
endmodule

// ### hdl/atig_top.sv
// Top of the two threshold event generators with register read path
// Overview of operation
// [R1] Source register read-only; bit7 zero, flags reset
// [R2] Active flag set when interrupt generated
// [R3] Axis flags show matching high/low events
// [R4] Reading source 1 clears flag, pin 1
// [R5] Latched mode freezes source until read
// [R6] Generator 2 identical, read clears pin 2
// [R7] Threshold seven bits, bit7 zero, reset zero
// [R8] Duration seven bits sets minimum persistence
// [R9] Duration step scales with sample rate
// [R10] Config: and/or, six-direction, six enables
// [R11] High enable requests above threshold
// [R12] Low enable requests below threshold
// [R13] Without six-direction: select picks OR/AND
// [R14] With six-direction: movement or position
// [R15] Generator 1 config at 30h, same layout
// [R16] OR any enabled, AND all enabled
// [R17] Unlatched flags follow condition, self clear
// [R18] Read-zero bits ignore writes, read zero
`timescale 1ns/1ps
module atig_top
  import atig_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_tick,
  input atig_sample_s sample,
  input wire logic latch1_enable,
  input wire logic latch2_enable,
  input atig_req_s req,
  output logic [7:0] rdata,
  output logic int1_pin,
  output logic int2_pin
);
  typedef struct packed {
    logic [7:0] rdata;
  } atig_top_state_s;

  atig_top_state_s st_reg;
  atig_top_state_s st_next;
  atig_gen_cfg_s cfg1;
  atig_gen_cfg_s cfg2;
  logic [7:0] src1;
  logic [7:0] src2;
  logic rd1;
  logic rd2;

  assign rd1 = req.rd && req.addr == ATIG_EVENT1_SOURCE_ADDR; // [R4]
  assign rd2 = req.rd && req.addr == ATIG_EVENT2_SOURCE_ADDR; // [R6]

  atig_regs u_regs (
    .clk(clk),
    .rst(rst),
    .req(req),
    .cfg1(cfg1),
    .cfg2(cfg2)
  );

  atig_event_gen u_gen1 (
    .clk(clk),
    .rst(rst),
    .sample_tick(sample_tick),
    .latch_enable(latch1_enable),
    .sample(sample),
    .cfg(cfg1),
    .source_read(rd1),
    .source_value(src1),
    .int_pin(int1_pin)
  );

  atig_event_gen u_gen2 (
    .clk(clk),
    .rst(rst),
    .sample_tick(sample_tick),
    .latch_enable(latch2_enable),
    .sample(sample),
    .cfg(cfg2),
    .source_read(rd2),
    .source_value(src2),
    .int_pin(int2_pin)
  );

  // Read data captured on the clock edge of the strobe, before the clear lands
  always_comb begin
    st_next = st_reg;
    if (req.rd) begin
      case (req.addr)
        ATIG_EVENT1_CONFIG_ADDR: st_next.rdata = {cfg1.and_or_select, cfg1.six_direction_enable,
                                                  cfg1.axis_enable}; // [R15]
        ATIG_EVENT1_SOURCE_ADDR: st_next.rdata = src1; // [R1]
        ATIG_EVENT1_THRESHOLD_ADDR: st_next.rdata = {1'b0, cfg1.threshold_level}; // [R18]
        ATIG_EVENT1_MIN_DURATION_ADDR: st_next.rdata = {1'b0, cfg1.duration_count};
        ATIG_EVENT2_CONFIG_ADDR: st_next.rdata = {cfg2.and_or_select, cfg2.six_direction_enable,
                                                  cfg2.axis_enable}; // [R10]
        ATIG_EVENT2_SOURCE_ADDR: st_next.rdata = src2; // [R1]
        ATIG_EVENT2_THRESHOLD_ADDR: st_next.rdata = {1'b0, cfg2.threshold_level}; // [R18]
        ATIG_EVENT2_MIN_DURATION_ADDR: st_next.rdata = {1'b0, cfg2.duration_count};
        default: st_next.rdata = ATIG_READ_ZERO;
      endcase
    end
    if (rst) begin
      st_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign rdata = st_reg.rdata;
endmodule

// ### test/atig_top_sva.sv
// Port checker for the two event generators
`timescale 1ns/1ps
module atig_top_sva
  import atig_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_tick,
  input atig_sample_s sample,
  input wire logic latch1_enable,
  input wire logic latch2_enable,
  input atig_req_s req,
  input wire logic [7:0] rdata,
  input wire logic int1_pin,
  input wire logic int2_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic rd1;
  logic rd2;
  assign rd1 = req.rd && req.addr == 8'h31;
  assign rd2 = req.rd && req.addr == 8'h35;
  chk_reset_clear: assert property (disable iff (1'b0) rst |=> !int1_pin && !int2_pin)
    else $error("pins not clear after reset");
  chk_pin1_cause: assert property ($rose(int1_pin) |-> $past(sample_tick) || $past(sample_tick, 2))
    else $error("pin 1 rose without a sample");
  // A tick may set the flag again on the read edge, so those cases are left out
  chk_read_clr1: assert property (rd1 && !sample_tick && !$past(sample_tick) |=> !int1_pin)
    else $error("pin 1 not cleared by source read");
  chk_read_clr2: assert property (rd2 && !sample_tick && !$past(sample_tick) |=> !int2_pin)
    else $error("pin 2 not cleared by source read");
  chk_latch_hold1: assert property (latch1_enable && int1_pin && !rd1 |=> int1_pin)
    else $error("latched pin 1 dropped without read");
  chk_latch_hold2: assert property (latch2_enable && int2_pin && !rd2 |=> int2_pin)
    else $error("latched pin 2 dropped without read");
  chk_unmapped_zero: assert property (req.rd && (req.addr < 8'h30 || req.addr > 8'h37)
    |-> ##[1:2] rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_field_bit7: assert property (req.rd && req.addr[7:3] == 5'h06 && req.addr[1:0] != 2'h0
    |-> ##[1:2] !rdata[7])
    else $error("bit 7 of a field read as one");
  cov_pin1: cover property ($rose(int1_pin));
  cov_latch1: cover property (latch1_enable && $rose(int1_pin));
  cov_pin2: cover property ($rose(int2_pin));
  cov_clear1: cover property (rd1 && int1_pin);
endmodule

bind atig_top atig_top_sva atig_top_sva_inst (.clk(clk), .rst(rst), .sample_tick(sample_tick),
  .sample(sample), .latch1_enable(latch1_enable), .latch2_enable(latch2_enable), .req(req),
  .rdata(rdata), .int1_pin(int1_pin), .int2_pin(int2_pin));

// ### test/atig_host_model.sv
// Host model issuing register strobes on the parallel request port
`timescale 1ns/1ps
module atig_host_model
  import atig_pkg::*;
(
  input wire logic clk,
  output atig_req_s req
);
  initial req = '0;
  // Idle cycle after each strobe keeps read data steady until it is checked
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    req <= '{wr: wr, rd: !wr, addr: addr, wdata: data};
    @(negedge clk);
    req <= '0;
    @(negedge clk);
  endtask
endmodule

// ### test/atig_top_test.sv
// Self-checking bench for both event generators
`timescale 1ns/1ps
module atig_top_test import atig_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sample_tick = 1'b0;
  logic latch1_enable = 1'b0;
  logic latch2_enable = 1'b1;
  logic rd_seen = 1'b0;
  atig_sample_s sample = '0;
  atig_req_s req;
  logic [7:0] rdata;
  logic int1_pin;
  logic int2_pin;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'hC1E05F33;
  int errors = 0;
  int check_count = 0;
  atig_top atig_top_inst (.clk(clk), .rst(rst), .sample_tick(sample_tick), .sample(sample),
    .latch1_enable(latch1_enable), .latch2_enable(latch2_enable), .req(req), .rdata(rdata),
    .int1_pin(int1_pin), .int2_pin(int2_pin));
  atig_host_model atig_host_model_inst (.clk(clk), .req(req));
  initial begin
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic give_verdict();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t read got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t pin got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    atig_host_model_inst.access(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    atig_host_model_inst.access(1'b0, a, 8'h00);
  endtask
  task automatic tick(input logic [7:0] x, input logic [7:0] y);
    @(negedge clk);
    sample <= {8'h00, y, x};
    sample_tick <= 1'b1;
    @(negedge clk);
    sample_tick <= 1'b0;
    @(negedge clk);
  endtask
  // Read data is settled one falling edge after the strobe is dropped
  always @(negedge clk) begin
    if (rd_seen) begin
      cmp_rd(rdata, exp_q.pop_front());
    end
    rd_seen <= req.rd;
  end
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst <= 1'b0;
    for (int a = 8'h2F; a < 8'h39; a++) begin
      rd(8'(a), 8'h00);
    end
    for (int m = 0; m < 4; m++) begin
      seed = xs(seed);
      wr(8'h30, {2'(m), seed[5:0]});
      rd(8'h30, {2'(m), seed[5:0]});
    end
    seed = xs(seed);
    wr(8'h36, seed[7:0]);
    rd(8'h36, {1'b0, seed[6:0]});
    wr(8'h31, 8'hFF);
    rd(8'h31, 8'h00);
    wr(8'h30, 8'h02);
    wr(8'h32, 8'h10);
    tick(8'h10, 8'h00);
    cmp_pin(int1_pin, 1'b0);
    tick(8'h14, 8'h00);
    cmp_pin(int1_pin, 1'b1);
    rd(8'h31, 8'h42);
    cmp_pin(int1_pin, 1'b0);
    tick(8'h00, 8'h00);
    rd(8'h31, 8'h00);
    wr(8'h30, 8'h8A);
    tick(8'h14, 8'h00);
    cmp_pin(int1_pin, 1'b0);
    tick(8'h14, 8'h14);
    cmp_pin(int1_pin, 1'b1);
    rd(8'h31, 8'h4A);
    wr(8'h34, 8'h01);
    wr(8'h36, 8'h10);
    wr(8'h37, 8'h02);
    repeat (2) tick(8'hEC, 8'h00);
    cmp_pin(int2_pin, 1'b0);
    tick(8'hEC, 8'h00);
    cmp_pin(int2_pin, 1'b1);
    tick(8'h00, 8'h00);
    cmp_pin(int2_pin, 1'b1);
    rd(8'h35, 8'h41);
    cmp_pin(int2_pin, 1'b0);
    // Latched generator 1 must hold across a quiet sample
    latch1_enable <= 1'b1;
    tick(8'h14, 8'h14);
    cmp_pin(int1_pin, 1'b1);
    tick(8'h00, 8'h00);
    cmp_pin(int1_pin, 1'b1);
    rd(8'h31, 8'h4A);
    cmp_pin(int1_pin, 1'b0);
    latch1_enable <= 1'b0;
    wr(8'h30, 8'h42);
    tick(8'h14, 8'h00);
    cmp_pin(int1_pin, 1'b1);
    tick(8'h14, 8'h00);
    cmp_pin(int1_pin, 1'b0);
    wr(8'h30, 8'hCA);
    tick(8'h14, 8'h14);
    cmp_pin(int1_pin, 1'b0);
    tick(8'h14, 8'h00);
    cmp_pin(int1_pin, 1'b1);
    // Mid-run reset while the pin is high
    rst <= 1'b1;
    @(negedge clk);
    rst <= 1'b0;
    cmp_pin(int1_pin, 1'b0);
    rd(8'h31, 8'h00);
    rd(8'h30, 8'h00);
    give_verdict();
  end
endmodule
